// File: timer_counter_capture.sv
`timescale 1ns/10ps
module timer_counter_capture (
  input  wire logic                            CLK_SYS_I,
  input  wire logic                            RESETN_I,
  input  wire logic                            TIMER_TICK_I,
  input  wire logic                            CENTER_ALIGN_SELECT_I,
  input  wire logic [15:0]                     MODULUS_I,
  input  wire logic                            OVERFLOW_IRQ_ENABLE_I,
  input  wire logic                            OVERFLOW_FLAG_CLEAR_I,
  input  wire logic                            COUNT_HIGH_BYTE_RD_I,
  input  wire logic                            COUNT_LOW_BYTE_RD_I,
  input  wire logic                            COUNT_WR_I,
  input  wire logic [2*timer_pkg::NUM_CH-1:0]  CHANNEL_MODE_I,
  input  wire logic [2*timer_pkg::NUM_CH-1:0]  CHANNEL_EDGE_SEL_I,
  input  wire logic [timer_pkg::NUM_CH-1:0]    CHANNEL_PIN_I,
  input  wire logic [timer_pkg::NUM_CH-1:0]    CAPTURE_VALUE_HIGH_RD_I,
  input  wire logic [timer_pkg::NUM_CH-1:0]    CAPTURE_VALUE_LOW_RD_I,
  input  wire logic [timer_pkg::NUM_CH-1:0]    CHANNEL_CTRL_STATUS_WR_I,
  output logic      [15:0]                     COUNT_O,
  output logic      [7:0]                      COUNT_RD_DATA_O,
  output logic                                 OVERFLOW_FLAG_O,
  output logic                                 OVERFLOW_IRQ_O,
  output logic      [8*timer_pkg::NUM_CH-1:0]  CAPTURE_RD_DATA_O,
  output logic      [timer_pkg::NUM_CH-1:0]    CAPTURE_EVENT_O
);
  logic [15:0]       count;
  timer_pkg::dir_t   dir;
  logic              overflow_flag;
  logic              irq;
  logic [15:0]       buffer;
  logic              pending;
  logic              hi_done;
  logic              lo_done;
  logic [7:0]        rd_data;
  logic [15:0]       next_count;
  timer_pkg::dir_t   next_dir;
  logic              next_overflow_flag;
  logic              next_irq;
  logic [15:0]       next_buffer;
  logic              next_pending;
  logic              next_hi_done;
  logic              next_lo_done;
  logic [7:0]        next_rd_data;

  localparam logic [15:0] CNT_ZERO_L = timer_pkg::CNT_ZERO;

  // counting and overflow
  always_comb begin
    logic [15:0] terminal;
    logic        ovf;
    terminal           = CNT_ZERO_L;
    ovf                = 1'b0;
    next_count         = count;
    next_dir           = dir;
    terminal = (MODULUS_I == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_MAX : MODULUS_I;
    if (COUNT_WR_I) begin
      next_count = timer_pkg::CNT_ZERO;
      next_dir   = timer_pkg::DIR_UP;
    end else if (TIMER_TICK_I) begin
      if (CENTER_ALIGN_SELECT_I) begin
        case (dir)
          timer_pkg::DIR_UP: begin
            if (count >= MODULUS_I) begin
              // reversal: modulus held one tick, then next lower count
              next_count = (MODULUS_I == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_ZERO
                                                              : MODULUS_I - timer_pkg::CNT_ONE;
              next_dir   = timer_pkg::DIR_DOWN;
              ovf        = 1'b1;
            end else begin
              next_count = count + timer_pkg::CNT_ONE;
            end
          end
          timer_pkg::DIR_DOWN: begin
            if (count == timer_pkg::CNT_ZERO) begin
              next_count = (MODULUS_I == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_ZERO
                                                              : timer_pkg::CNT_ONE;
              next_dir   = timer_pkg::DIR_UP;
            end else begin
              next_count = count - timer_pkg::CNT_ONE;
            end
          end
          default: begin
            next_dir = timer_pkg::DIR_UP;
          end
        endcase
      end else begin
        next_dir = timer_pkg::DIR_UP;
        if (count >= terminal) begin
          next_count = timer_pkg::CNT_ZERO;
          ovf        = 1'b1;
        end else begin
          next_count = count + timer_pkg::CNT_ONE;
        end
      end
    end
    // set wins over a clear in the same cycle
    next_overflow_flag = ovf || (overflow_flag && !OVERFLOW_FLAG_CLEAR_I);
    next_irq           = next_overflow_flag && OVERFLOW_IRQ_ENABLE_I;
  end

  // coherent two-byte counter reads
  always_comb begin
    logic [15:0] src;
    src          = CNT_ZERO_L;
    next_buffer  = buffer;
    next_pending = pending;
    next_hi_done = hi_done;
    next_lo_done = lo_done;
    next_rd_data = rd_data;
    if (COUNT_WR_I) begin
      next_pending = 1'b0;
      next_hi_done = 1'b0;
      next_lo_done = 1'b0;
    end else if (COUNT_HIGH_BYTE_RD_I || COUNT_LOW_BYTE_RD_I) begin
      src = pending ? buffer : count;
      if (!pending) begin
        next_buffer = count;
      end
      next_rd_data = COUNT_HIGH_BYTE_RD_I ? src[timer_pkg::HI_MSB:timer_pkg::HI_LSB]
                                          : src[timer_pkg::LO_MSB:0];
      if ((hi_done || COUNT_HIGH_BYTE_RD_I) &&
          (lo_done || (COUNT_LOW_BYTE_RD_I && !COUNT_HIGH_BYTE_RD_I))) begin
        next_pending = 1'b0;
        next_hi_done = 1'b0;
        next_lo_done = 1'b0;
      end else begin
        next_pending = 1'b1;
        next_hi_done = hi_done || COUNT_HIGH_BYTE_RD_I;
        next_lo_done = lo_done || (COUNT_LOW_BYTE_RD_I && !COUNT_HIGH_BYTE_RD_I);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      count         <= timer_pkg::CNT_ZERO;
      dir           <= timer_pkg::DIR_UP;
      overflow_flag <= 1'b0;
      irq           <= 1'b0;
      buffer        <= timer_pkg::CNT_ZERO;
      pending       <= 1'b0;
      hi_done       <= 1'b0;
      lo_done       <= 1'b0;
      rd_data       <= timer_pkg::BYTE_RESET;
    end else begin
      count         <= next_count;
      dir           <= next_dir;
      overflow_flag <= next_overflow_flag;
      irq           <= next_irq;
      buffer        <= next_buffer;
      pending       <= next_pending;
      hi_done       <= next_hi_done;
      lo_done       <= next_lo_done;
      rd_data       <= next_rd_data;
    end
  end

  assign COUNT_O         = count;
  assign COUNT_RD_DATA_O = rd_data;
  assign OVERFLOW_FLAG_O = overflow_flag;
  assign OVERFLOW_IRQ_O  = irq;

  timer_ch_if ch_bus [timer_pkg::NUM_CH] ();

  genvar gi;
  generate
    for (gi = 0; gi < timer_pkg::NUM_CH; gi++) begin : g_ch
      assign ch_bus[gi].count               = count;
      assign ch_bus[gi].center_align_select = CENTER_ALIGN_SELECT_I;
      assign ch_bus[gi].channel_mode        = CHANNEL_MODE_I[2*gi+1:2*gi];
      assign ch_bus[gi].edge_sel            = CHANNEL_EDGE_SEL_I[2*gi+1:2*gi];
      assign ch_bus[gi].pin                 = CHANNEL_PIN_I[gi];
      assign ch_bus[gi].rd_hi               = CAPTURE_VALUE_HIGH_RD_I[gi];
      assign ch_bus[gi].rd_lo               = CAPTURE_VALUE_LOW_RD_I[gi];
      assign ch_bus[gi].ctrl_wr             = CHANNEL_CTRL_STATUS_WR_I[gi];
      assign CAPTURE_RD_DATA_O[8*gi+7:8*gi] = ch_bus[gi].rd_data;
      assign CAPTURE_EVENT_O[gi]            = ch_bus[gi].capture_event;

      capture_channel u_ch (
        .clk_i    (CLK_SYS_I),
        .resetn_i (RESETN_I),
        .ch       (ch_bus[gi])
      );
    end
  endgenerate
endmodule // timer_counter_capture

// File: timer_pkg.sv
package timer_pkg;
  localparam int          NUM_CH        = 2;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] MOD_RESET     = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  // channel mode field, valid only with center alignment off
  localparam logic [1:0]  MODE_CAPTURE  = 2'h0;
  localparam logic [1:0]  MODE_COMPARE  = 2'h1;
  // capture edge select
  localparam logic [1:0]  EDGE_OFF      = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  localparam int          HI_MSB        = 15;
  localparam int          HI_LSB        = 8;
  localparam int          LO_MSB        = 7;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

// File: timer_ch_if.sv
`timescale 1ns/10ps
interface timer_ch_if;
  logic [15:0] count;
  logic        center_align_select;
  logic [1:0]  channel_mode;
  logic [1:0]  edge_sel;
  logic        pin;
  logic        rd_hi;
  logic        rd_lo;
  logic        ctrl_wr;
  logic [7:0]  rd_data;
  logic        capture_event;

  modport timer (
    output count, center_align_select, channel_mode, edge_sel, pin, rd_hi, rd_lo, ctrl_wr,
    input  rd_data, capture_event
  );
  modport chan (
    input  count, center_align_select, channel_mode, edge_sel, pin, rd_hi, rd_lo, ctrl_wr,
    output rd_data, capture_event
  );
endinterface

// File: capture_channel.sv
`timescale 1ns/10ps
module capture_channel (
  input  wire logic  clk_i,
  input  wire logic  resetn_i,
  timer_ch_if.chan   ch
);
  logic [15:0] value;
  logic [15:0] buffer;
  logic        pending;
  logic        hi_done;
  logic        lo_done;
  logic        pin_prev;
  logic [7:0]  rd_data;
  logic        capture_event;
  logic [15:0] next_value;
  logic [15:0] next_buffer;
  logic        next_pending;
  logic        next_hi_done;
  logic        next_lo_done;
  logic [7:0]  next_rd_data;
  logic        next_capture_event;

  localparam logic [15:0] CNT_ZERO_W = timer_pkg::CNT_ZERO;

  always_comb begin
    logic        is_capture;
    logic        active;
    logic [15:0] src;
    is_capture = 1'b0;
    active     = 1'b0;
    src        = CNT_ZERO_W;
    next_value   = value;
    next_buffer  = buffer;
    next_pending = pending;
    next_hi_done = hi_done;
    next_lo_done = lo_done;
    next_rd_data = rd_data;
    next_capture_event = 1'b0;
    is_capture = !ch.center_align_select && (ch.channel_mode == timer_pkg::MODE_CAPTURE);
    case (ch.edge_sel)
      timer_pkg::EDGE_RISE: active = ch.pin && !pin_prev;
      timer_pkg::EDGE_FALL: active = !ch.pin && pin_prev;
      timer_pkg::EDGE_BOTH: active = ch.pin != pin_prev;
      default:              active = 1'b0;
    endcase
    if (is_capture && active) begin
      next_value         = ch.count;
      next_capture_event = 1'b1;
    end
    if (ch.ctrl_wr) begin
      next_pending = 1'b0;
      next_hi_done = 1'b0;
      next_lo_done = 1'b0;
    end else if (ch.rd_hi || ch.rd_lo) begin
      src = pending ? buffer : value;
      if (!pending) begin
        next_buffer = value;
      end
      next_rd_data = ch.rd_hi ? src[timer_pkg::HI_MSB:timer_pkg::HI_LSB]
                              : src[timer_pkg::LO_MSB:0];
      if ((hi_done || ch.rd_hi) && (lo_done || ch.rd_lo && !ch.rd_hi)) begin
        next_pending = 1'b0;
        next_hi_done = 1'b0;
        next_lo_done = 1'b0;
      end else begin
        next_pending = 1'b1;
        next_hi_done = hi_done || ch.rd_hi;
        next_lo_done = lo_done || (ch.rd_lo && !ch.rd_hi);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      value         <= timer_pkg::CNT_ZERO;
      buffer        <= timer_pkg::CNT_ZERO;
      pending       <= 1'b0;
      hi_done       <= 1'b0;
      lo_done       <= 1'b0;
      pin_prev      <= 1'b0;
      rd_data       <= timer_pkg::BYTE_RESET;
      capture_event <= 1'b0;
    end else begin
      value         <= next_value;
      buffer        <= next_buffer;
      pending       <= next_pending;
      hi_done       <= next_hi_done;
      lo_done       <= next_lo_done;
      pin_prev      <= ch.pin;
      rd_data       <= next_rd_data;
      capture_event <= next_capture_event;
    end
  end

  assign ch.rd_data       = rd_data;
  assign ch.capture_event = capture_event;
endmodule // capture_channel

// File: pin_source.sv
`timescale 1ns/10ps
module pin_source (
  input  wire logic       clk_i,
  input  wire logic [1:0] level_i,
  output logic      [1:0] pin_o = 2'h0
);
  // external events move only between sampling edges
  always @(negedge clk_i) begin
    pin_o <= level_i;
  end
endmodule // pin_source

// File: timer_counter_capture_assertions.sv
`timescale 1ns/10ps
module timer_counter_capture_assertions (
  input wire logic                           CLK_SYS_I,
  input wire logic                           RESETN_I,
  input wire logic                           TIMER_TICK_I,
  input wire logic                           CENTER_ALIGN_SELECT_I,
  input wire logic [15:0]                    MODULUS_I,
  input wire logic                           OVERFLOW_IRQ_ENABLE_I,
  input wire logic                           OVERFLOW_FLAG_CLEAR_I,
  input wire logic                           COUNT_WR_I,
  input wire logic [2*timer_pkg::NUM_CH-1:0] CHANNEL_MODE_I,
  input wire logic [2*timer_pkg::NUM_CH-1:0] CHANNEL_EDGE_SEL_I,
  input wire logic [timer_pkg::NUM_CH-1:0]   CHANNEL_PIN_I,
  input wire logic [15:0]                    COUNT_O,
  input wire logic                           OVERFLOW_FLAG_O,
  input wire logic                           OVERFLOW_IRQ_O,
  input wire logic [timer_pkg::NUM_CH-1:0]   CAPTURE_EVENT_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  sequence up_tick;
    TIMER_TICK_I && !COUNT_WR_I && !CENTER_ALIGN_SELECT_I;
  endsequence
  sequence ctr_tick;
    TIMER_TICK_I && !COUNT_WR_I && CENTER_ALIGN_SELECT_I && MODULUS_I != 16'h0000;
  endsequence
  irq_level_a: assert property ($past(RESETN_I) |->
    OVERFLOW_IRQ_O == (OVERFLOW_FLAG_O && $past(OVERFLOW_IRQ_ENABLE_I))) else $error("irq level");
  flag_sticky_a: assert property (OVERFLOW_FLAG_O && !OVERFLOW_FLAG_CLEAR_I |=>
    OVERFLOW_FLAG_O) else $error("flag lost");
  count_clear_a: assert property (COUNT_WR_I |=> COUNT_O == 16'h0000)
    else $error("count not cleared");
  full_wrap_a: assert property (up_tick ##0 (MODULUS_I == 16'h0000 && COUNT_O == 16'hffff)
    |=> COUNT_O == 16'h0000 && OVERFLOW_FLAG_O) else $error("full wrap");
  mod_wrap_a: assert property (up_tick ##0 (MODULUS_I != 16'h0000 && COUNT_O == MODULUS_I)
    |=> COUNT_O == 16'h0000 && OVERFLOW_FLAG_O) else $error("modulus wrap");
  up_step_a: assert property (up_tick ##0 ((MODULUS_I == 16'h0000 && COUNT_O != 16'hffff)
    || COUNT_O < MODULUS_I) |=> COUNT_O == $past(COUNT_O) + 16'h0001) else $error("up step");
  turn_down_a: assert property (ctr_tick ##0 (COUNT_O == MODULUS_I) |=>
    COUNT_O == $past(MODULUS_I) - 16'h0001 && OVERFLOW_FLAG_O) else $error("turn down");
  turn_up_a: assert property (ctr_tick ##0 (COUNT_O == 16'h0000) |=> COUNT_O == 16'h0001)
    else $error("turn up");
  cap_event_a: assert property (!CENTER_ALIGN_SELECT_I && CHANNEL_MODE_I[1:0] == 2'h0 &&
    ((CHANNEL_EDGE_SEL_I[0] && $rose(CHANNEL_PIN_I[0])) ||
     (CHANNEL_EDGE_SEL_I[1] && $fell(CHANNEL_PIN_I[0]))) |=> CAPTURE_EVENT_O[0])
    else $error("capture event");
endmodule // timer_counter_capture_assertions

bind timer_counter_capture timer_counter_capture_assertions chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .TIMER_TICK_I(TIMER_TICK_I),
  .CENTER_ALIGN_SELECT_I(CENTER_ALIGN_SELECT_I), .MODULUS_I(MODULUS_I),
  .OVERFLOW_IRQ_ENABLE_I(OVERFLOW_IRQ_ENABLE_I), .OVERFLOW_FLAG_CLEAR_I(OVERFLOW_FLAG_CLEAR_I),
  .COUNT_WR_I(COUNT_WR_I), .CHANNEL_MODE_I(CHANNEL_MODE_I),
  .CHANNEL_EDGE_SEL_I(CHANNEL_EDGE_SEL_I), .CHANNEL_PIN_I(CHANNEL_PIN_I), .COUNT_O(COUNT_O),
  .OVERFLOW_FLAG_O(OVERFLOW_FLAG_O), .OVERFLOW_IRQ_O(OVERFLOW_IRQ_O),
  .CAPTURE_EVENT_O(CAPTURE_EVENT_O));

// File: timer_counter_capture_test.sv
`timescale 1ns/10ps
module timer_counter_capture_test;
  logic        clk = 1'b0, rstn = 1'b0, tick = 1'b0, ctr = 1'b0, ien = 1'b0, fclr = 1'b0;
  logic        rd_hi = 1'b0, rd_lo = 1'b0, wr = 1'b0, flag, irq;
  logic [15:0] modv = 16'h0000, count, crdata;
  logic [3:0]  mode = 4'h0, esel = 4'h0;
  logic [1:0]  pin_req = 2'h0, pins, crd_hi = 2'h0, crd_lo = 2'h0, cwr = 2'h0, cev;
  logic [7:0]  rdata;
  int          errors = 0, checked = 0, cycles = 0;
  always #5 clk = ~clk;
  pin_source src_u (.clk_i(clk), .level_i(pin_req), .pin_o(pins));
  timer_counter_capture dut_u (.CLK_SYS_I(clk), .RESETN_I(rstn), .TIMER_TICK_I(tick),
    .CENTER_ALIGN_SELECT_I(ctr), .MODULUS_I(modv), .OVERFLOW_IRQ_ENABLE_I(ien),
    .OVERFLOW_FLAG_CLEAR_I(fclr), .COUNT_HIGH_BYTE_RD_I(rd_hi), .COUNT_LOW_BYTE_RD_I(rd_lo),
    .COUNT_WR_I(wr), .CHANNEL_MODE_I(mode), .CHANNEL_EDGE_SEL_I(esel), .CHANNEL_PIN_I(pins),
    .CAPTURE_VALUE_HIGH_RD_I(crd_hi), .CAPTURE_VALUE_LOW_RD_I(crd_lo),
    .CHANNEL_CTRL_STATUS_WR_I(cwr), .COUNT_O(count), .COUNT_RD_DATA_O(rdata),
    .OVERFLOW_FLAG_O(flag), .OVERFLOW_IRQ_O(irq), .CAPTURE_RD_DATA_O(crdata),
    .CAPTURE_EVENT_O(cev));
  task automatic print_verdict;
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ticks(input int n);
    tick = 1'b1;
    step(n);
    tick = 1'b0;
  endtask
  task automatic clr_cnt;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic fclear;
    fclr = 1'b1;
    step(1);
    fclr = 1'b0;
  endtask
  task automatic rd_cnt(input logic hi, input logic [7:0] exp);
    rd_hi = hi;
    rd_lo = !hi;
    step(1);
    rd_hi = 1'b0;
    rd_lo = 1'b0;
    step(1);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic rd_cap(input int ch, input logic hi, input logic [7:0] exp);
    crd_hi[ch] = hi;
    crd_lo[ch] = !hi;
    step(1);
    crd_hi = 2'h0;
    crd_lo = 2'h0;
    step(1);
    chk({8'h00, crdata[8*ch+:8]}, {8'h00, exp});
  endtask
  task automatic set_pins(input logic [1:0] v);
    pin_req <= v;
    step(2);
  endtask
  // timeout: longest run is about 70300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      print_verdict;
    end
  end
  logic [3:0] tab [4] = '{4'h1, 4'h2, 4'h3, 4'h7};
  logic [7:0] exp [4] = '{8'h05, 8'h07, 8'h08, 8'h08};
  initial begin
    step(16);
    rstn = 1'b1;
    clr_cnt;
    ticks(16'h1234);
    rd_cnt(1'b1, 8'h12);
    ticks(5);
    rd_cnt(1'b0, 8'h34);
    rd_cnt(1'b1, 8'h12);
    rd_cnt(1'b0, 8'h39);
    rd_cnt(1'b1, 8'h12);
    clr_cnt;
    ticks(3);
    rd_cnt(1'b0, 8'h03);
    ticks(16'hfffd);
    chk(count, 16'h0000);
    chk(flag, 16'h0001);
    chk(irq, 16'h0000);
    ien = 1'b1;
    step(1);
    chk(irq, 16'h0001);
    fclear;
    chk(flag, 16'h0000);
    modv = 16'h0003;
    clr_cnt;
    ticks(3);
    chk(flag, 16'h0000);
    ticks(1);
    chk(count, 16'h0000);
    chk(flag, 16'h0001);
    fclear;
    ctr = 1'b1;
    clr_cnt;
    ticks(3);
    chk(count, 16'h0003);
    ticks(1);
    chk(count, 16'h0002);
    chk(flag, 16'h0001);
    ticks(2);
    chk(count, 16'h0000);
    ticks(1);
    chk(count, 16'h0001);
    ctr = 1'b0;
    modv = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      mode = {2{tab[i][3:2]}};
      esel = {2{tab[i][1:0]}};
      clr_cnt;
      ticks(5 + i);
      set_pins(2'h3);
      ticks(1);
      set_pins(2'h0);
      rd_cap(0, 1'b0, exp[i]);
      rd_cap(1, 1'b0, exp[i]);
      rd_cap(1, 1'b1, 8'h00);
      rd_cap(0, 1'b1, 8'h00);
    end
    mode = 4'h0;
    rd_cap(0, 1'b1, 8'h00);
    set_pins(2'h3);
    rd_cap(0, 1'b0, 8'h08);
    rd_cap(0, 1'b1, 8'h00);
    ticks(1);
    set_pins(2'h0);
    cwr = 2'h1;
    step(1);
    cwr = 2'h0;
    rd_cap(0, 1'b0, 8'h0a);
    print_verdict;
  end
endmodule // timer_counter_capture_test
